// >>> compare_channel.sv
// compare channel: double buffered compare value, match detect and waveform output
`timescale 1ns/10ps
`default_nettype none
module compare_channel (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        tick,
    input  wire logic        write,
    input  wire logic [15:0] writeData,
    input  wire logic [15:0] writeMask,
    input  wire logic        load,
    input  wire logic [15:0] counterValue,
    input  wire logic [15:0] top,
    input  wire logic        dualSlope,
    input  wire logic        countDown,
    input  wire logic        atTop,
    input  wire logic [1:0]  outputModeBits,
    input  wire logic        toggleAllowed,
    input  wire logic        pinDirectionBit,
    input  wire logic        portValue,
    output logic [15:0]      bufferValue,
    output logic [15:0]      compareValue,
    output logic             match,
    output logic             pinOut
);
    import pwm_pkg::*;
    logic waveLevel;
    logic next_waveLevel;
    logic hitTopSpecial;
    logic connected;
    // compare every enabled timer cycle, independent of output mode
    assign match = tick && (counterValue == compareValue);
    assign hitTopSpecial = (compareValue == top) && outputModeBits[1];
    assign connected = (outputModeBits != 2'b00) && (outputModeBits != 2'b01 || toggleAllowed);
    // waveform next state
    always_comb begin
        next_waveLevel = waveLevel;
        if (tick && outputModeBits == 2'b01 && toggleAllowed && match) begin
            next_waveLevel = ~waveLevel; // toggle on each match
        end else if (tick && outputModeBits[1]) begin
            if (!dualSlope) begin
                // fast: top set/clear wins, match at top ignored
                if (atTop) next_waveLevel = ~outputModeBits[0];
                else if (match && !hitTopSpecial) next_waveLevel = outputModeBits[0];
            end else if (match) begin
                // clear up / set down for mode two, opposite for three
                next_waveLevel = countDown ? ~outputModeBits[0] : outputModeBits[0];
            end
        end
    end
    // buffer write with fixed-top masking, load at update point
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bufferValue  <= VALUE_RESET;
            compareValue <= VALUE_RESET;
            waveLevel    <= 1'b0;
        end else begin
            if (write) bufferValue <= writeData & writeMask;
            if (load) compareValue <= bufferValue;
            waveLevel <= next_waveLevel;
        end
    end
    // pin shows waveform only when direction bit selects output
    assign pinOut = (pinDirectionBit && connected) ? waveLevel : portValue;
endmodule
`default_nettype wire

// >>> prescaler.sv
// prescaler: timer clock enable at io clock divided by 1, 8, 64, 256 or 1024
`timescale 1ns/10ps
`default_nettype none
module prescaler (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [2:0] select,
    output logic            tick
);
    import pwm_pkg::*;
    logic [9:0] divCount;
    logic       tap;
    // select 1..5 chooses the factor, 0 stops the timer, 6..7 stop as well
    assign tap = (select == 3'h1) ? 1'b1 :
                 (select == 3'h2) ? (divCount[2:0] == 3'(DIV_8 - 1)) :
                 (select == 3'h3) ? (divCount[5:0] == 6'(DIV_64 - 1)) :
                 (select == 3'h4) ? (divCount[7:0] == 8'(DIV_256 - 1)) :
                 (select == 3'h5) ? (divCount == 10'(DIV_1024 - 1)) : 1'b0;
    assign tick = tap;
    // free running divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) divCount <= 10'h000;
        else divCount <= divCount + 10'h001;
    end
endmodule
`default_nettype wire

// >>> pwm_checker.sv
// checker: bus answer, register readback and pin routing assertions for the pwm timer
`timescale 1ns/10ps
`default_nettype none
module pwm_checker
    import pwm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  portValue,
    input wire logic        compareOutputA,
    input wire logic        compareOutputB
);
    logic       rPend;
    logic       wPend;
    logic       far;
    logic [7:0] addr;
    logic [7:0] ctrlA;
    logic [1:0] dir;
    // address phase taken, and pins left to the port
    wire logic take = hsel && hready && htrans[1];
    wire logic offA = ctrlA[7:6] == 2'b00 || !dir[0];
    wire logic offB = ctrlA[5:4] == 2'b00 || !dir[1];
    // mirror the address phase and the control and direction writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rPend <= 1'b0;
            wPend <= 1'b0;
            far   <= 1'b0;
            addr  <= 8'h00;
            ctrlA <= 8'h00;
            dir   <= 2'h0;
        end else begin
            rPend <= take && !hwrite;
            wPend <= take && hwrite;
            if (take) begin
                addr <= haddr[7:0];
                far  <= haddr > 32'h0000001F;
            end
            if (wPend && !far && addr == CTRL_A_OFFSET) begin
                ctrlA <= hwdata[7:0];
            end
            if (wPend && !far && addr == PIN_DIR_OFFSET) begin
                dir <= hwdata[1:0];
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("bus ready dropped");
    unmapped_zero_a: assert property (rPend && far |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (rPend && !far && addr == CTRL_A_OFFSET |-> hrdata == {24'h000000, ctrlA & 8'hF3})
        else $error("control a readback wrong");
    flags_width_a: assert property (rPend && !far && addr == FLAGS_OFFSET |-> hrdata[31:4] == 28'h0000000)
        else $error("flag register upper bits set");
    dir_readback_a: assert property (rPend && !far && addr == PIN_DIR_OFFSET |-> hrdata == {30'h0, dir})
        else $error("direction readback wrong");
    pin_a_port_a: assert property (offA |-> compareOutputA == portValue[0])
        else $error("pin a not following port");
    pin_b_port_a: assert property (offB |-> compareOutputB == portValue[1])
        else $error("pin b not following port");
    cover property (take && hwrite);
    cover property (rPend && far);
    cover property (!offB && $rose(compareOutputB));
endmodule
bind timer16_dual_slope_pwm pwm_checker #(.WIDTH(WIDTH)) chk (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .portValue(portValue), .compareOutputA(compareOutputA),
    .compareOutputB(compareOutputB));
`default_nettype wire

// >>> pwm_load.sv
// load model: watches a pwm pin and reports its period and high time in clock cycles
`timescale 1ns/10ps
`default_nettype none
module pwm_load (
    input  wire logic   clk,
    input  wire logic   pinA,
    input  wire logic   pinB,
    input  wire logic   pick,
    input  wire logic   arm,
    output logic        measValid,
    output logic [31:0] measValue
);
    int cyc = 0;
    int t0;
    int t1;
    // free running cycle count
    always @(posedge clk) cyc <= cyc + 1;
    // wait for the chosen pin to change to the wanted level
    task automatic waitFor(input logic want);
        logic old;
        do begin
            old = pick ? pinB : pinA;
            @(posedge clk);
        end while (!((pick ? pinB : pinA) === want && old !== want));
    endtask
    // skip the first rise so the waveform has settled, then time one period from the second
    initial begin
        measValid = 1'b0;
        measValue = 32'h00000000;
        forever begin
            @(posedge clk iff arm);
            waitFor(1'b1);
            waitFor(1'b1);
            t0 = cyc;
            waitFor(1'b0);
            t1 = cyc;
            waitFor(1'b1);
            measValue <= {t1[15:0] - t0[15:0], cyc[15:0] - t0[15:0]};
            measValid <= 1'b1;
            @(posedge clk);
            measValid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> pwm_pkg.sv
// package: register map, field layout, fixed tops and timing constants of the pwm timer
package pwm_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_A_OFFSET   = 8'h00;
    localparam logic [7:0] CTRL_B_OFFSET   = 8'h04;
    localparam logic [7:0] COUNTER_OFFSET  = 8'h08;
    localparam logic [7:0] CMP_A_OFFSET    = 8'h0C;
    localparam logic [7:0] CMP_B_OFFSET    = 8'h10;
    localparam logic [7:0] CAP_TOP_OFFSET  = 8'h14;
    localparam logic [7:0] FLAGS_OFFSET    = 8'h18;
    localparam logic [7:0] PIN_DIR_OFFSET  = 8'h1C;
    // field positions
    localparam int COM_A_LSB   = 6;
    localparam int COM_B_LSB   = 4;
    localparam int WGM_LO_LSB  = 0;
    localparam int WGM_HI_LSB  = 3;
    localparam int CS_LSB      = 0;
    localparam int OVF_BIT     = 0;
    localparam int CMPA_BIT    = 1;
    localparam int CMPB_BIT    = 2;
    localparam int CAP_BIT     = 3;
    // reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] VALUE_RESET   = 16'h0000;
    // fixed tops
    localparam logic [15:0] TOP_8BIT      = 16'h00FF;
    localparam logic [15:0] TOP_9BIT      = 16'h01FF;
    localparam logic [15:0] TOP_10BIT     = 16'h03FF;
    localparam logic [15:0] BOTTOM        = 16'h0000;
    localparam logic [15:0] MAX_VALUE     = 16'hFFFF;
    // prescaler divide figures
    localparam int DIV_8    = 8;
    localparam int DIV_64   = 64;
    localparam int DIV_256  = 256;
    localparam int DIV_1024 = 1024;
    // bus transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
    // count direction
    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage

// >>> timer16_dual_slope_pwm.sv
// 16-bit pwm timer: ahb-lite registers, dual and single slope counter, two compare channels
`timescale 1ns/10ps
`default_nettype none
module timer16_dual_slope_pwm #(
    parameter int WIDTH = 16
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [1:0]  portValue,
    output logic             compareOutputA,
    output logic             compareOutputB
);
    import pwm_pkg::*;

    // registers
    logic [7:0]       ctrlA;
    logic [7:0]       ctrlB;
    logic [WIDTH-1:0] counterValue;
    logic [WIDTH-1:0] captureTopValue;
    logic [3:0]       flags;
    logic [1:0]       pinDirection;
    dir_t             direction;
    logic [31:0]      readData;

    // bus address phase capture
    logic       dataPhase;
    logic       dataWrite;
    logic [7:0] dataAddr;
    logic       addrValid;
    assign addrValid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr  <= 8'h00;
        end else if (hready) begin
            dataPhase <= addrValid;
            dataWrite <= hwrite;
            dataAddr  <= haddr[7:0];
        end
    end
    // slave always ready, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // write strobes per register
    logic wrEn;
    logic wrCtrlA;
    logic wrCtrlB;
    logic wrCounter;
    logic wrCmpA;
    logic wrCmpB;
    logic wrCapTop;
    logic wrFlags;
    logic wrPinDir;
    assign wrEn      = dataPhase && dataWrite;
    assign wrCtrlA   = wrEn && (dataAddr == CTRL_A_OFFSET);
    assign wrCtrlB   = wrEn && (dataAddr == CTRL_B_OFFSET);
    assign wrCounter = wrEn && (dataAddr == COUNTER_OFFSET);
    assign wrCmpA    = wrEn && (dataAddr == CMP_A_OFFSET);
    assign wrCmpB    = wrEn && (dataAddr == CMP_B_OFFSET);
    assign wrCapTop  = wrEn && (dataAddr == CAP_TOP_OFFSET);
    assign wrFlags   = wrEn && (dataAddr == FLAGS_OFFSET);
    assign wrPinDir  = wrEn && (dataAddr == PIN_DIR_OFFSET);

    // mode decode from split mode fields
    logic [3:0] waveformModeBits;
    logic [1:0] outputModeBitsA;
    logic [1:0] outputModeBitsB;
    logic [2:0] clockSelect;
    assign waveformModeBits = {ctrlB[WGM_HI_LSB+1 -: 2], ctrlA[WGM_LO_LSB +: 2]};
    assign outputModeBitsA  = ctrlA[COM_A_LSB +: 2];
    assign outputModeBitsB  = ctrlA[COM_B_LSB +: 2];
    assign clockSelect      = ctrlB[CS_LSB +: 3];

    // mode classes
    logic phaseCorrect;
    logic freqCorrect;
    logic fastPwm;
    logic dualSlope;
    logic fixedTop;
    logic topIsCmpA;
    logic topIsCapture;
    assign phaseCorrect = (waveformModeBits == 4'h1) || (waveformModeBits == 4'h2) || (waveformModeBits == 4'h3)
                       || (waveformModeBits == 4'hA) || (waveformModeBits == 4'hB);
    assign freqCorrect  = (waveformModeBits == 4'h8) || (waveformModeBits == 4'h9);
    assign fastPwm      = (waveformModeBits == 4'h5) || (waveformModeBits == 4'h6) || (waveformModeBits == 4'h7)
                       || (waveformModeBits == 4'hE) || (waveformModeBits == 4'hF);
    assign dualSlope    = phaseCorrect || freqCorrect;
    assign fixedTop     = (waveformModeBits[3] == 1'b0) && (waveformModeBits[1:0] != 2'b00) && (phaseCorrect || fastPwm);
    assign topIsCmpA    = (waveformModeBits == 4'h9) || (waveformModeBits == 4'hB) || (waveformModeBits == 4'hF);
    assign topIsCapture = (waveformModeBits == 4'h8) || (waveformModeBits == 4'hA) || (waveformModeBits == 4'hE);

    // top source selection
    logic [WIDTH-1:0] compareValueA;
    logic [WIDTH-1:0] compareValueB;
    logic [WIDTH-1:0] top;
    logic [WIDTH-1:0] writeMask;
    assign top = topIsCmpA    ? compareValueA :
                 topIsCapture ? captureTopValue :
                 (waveformModeBits[1:0] == 2'b01) ? TOP_8BIT :
                 (waveformModeBits[1:0] == 2'b10) ? TOP_9BIT :
                 (waveformModeBits[1:0] == 2'b11) ? TOP_10BIT : MAX_VALUE;
    assign writeMask = fixedTop ? top : MAX_VALUE;

    // timer clock enable from prescaler
    logic tick;
    prescaler u_prescaler (
        .clk    (clk),
        .nrst   (nrst),
        .select (clockSelect),
        .tick   (tick)
    );

    // counter events; software keeps top >= 3 and >= compares
    logic atTop;
    logic atBottom;
    logic updateAtTop;
    logic updateAtBottom;
    logic loadCompares;
    assign atTop          = (counterValue == top);
    assign atBottom       = (counterValue == BOTTOM);
    assign updateAtTop    = tick && atTop && (phaseCorrect || fastPwm);
    assign updateAtBottom = tick && atBottom && freqCorrect;
    assign loadCompares   = updateAtTop || updateAtBottom || !(dualSlope || fastPwm);

    // next counter and direction
    logic [WIDTH-1:0] next_counterValue;
    dir_t             next_direction;
    always_comb begin
        next_counterValue = counterValue;
        next_direction    = direction;
        if (tick) begin
            if (dualSlope) begin
                // hold top exactly one tick then count down
                if (atTop) begin
                    next_direction    = DIR_DOWN;
                    next_counterValue = counterValue - 16'h0001;
                end else if (direction == DIR_DOWN && atBottom) begin
                    next_direction    = DIR_UP;
                    next_counterValue = counterValue + 16'h0001;
                end else if (direction == DIR_DOWN) begin
                    next_counterValue = counterValue - 16'h0001;
                end else begin
                    next_counterValue = counterValue + 16'h0001;
                end
            end else begin
                next_direction    = DIR_UP;
                next_counterValue = (fastPwm && atTop) ? BOTTOM : counterValue + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            counterValue <= VALUE_RESET;
            direction    <= DIR_UP;
        end else if (wrCounter) begin
            counterValue <= hwdata[WIDTH-1:0];
            direction    <= direction;
        end else begin
            counterValue <= next_counterValue;
            direction    <= next_direction;
        end
    end

    // compare channels
    logic matchA;
    logic matchB;
    logic countDown;
    // a match at bottom counts as up-counting, so a bottom compare holds low in mode two and high in mode three
    assign countDown = ((direction == DIR_DOWN) && !atBottom) || (dualSlope && atTop);
    compare_channel u_channel_a (
        .clk             (clk),
        .nrst            (nrst),
        .tick            (tick),
        .write           (wrCmpA),
        .writeData       (hwdata[WIDTH-1:0]),
        .writeMask       (writeMask),
        .load            (loadCompares),
        .counterValue    (counterValue),
        .top             (top),
        .dualSlope       (dualSlope),
        .countDown       (countDown),
        .atTop           (atTop),
        .outputModeBits  (outputModeBitsA),
        .toggleAllowed   (waveformModeBits[3]),
        .pinDirectionBit (pinDirection[0]),
        .portValue       (portValue[0]),
        .bufferValue     (),
        .compareValue    (compareValueA),
        .match           (matchA),
        .pinOut          (compareOutputA)
    );
    compare_channel u_channel_b (
        .clk             (clk),
        .nrst            (nrst),
        .tick            (tick),
        .write           (wrCmpB),
        .writeData       (hwdata[WIDTH-1:0]),
        .writeMask       (writeMask),
        .load            (loadCompares),
        .counterValue    (counterValue),
        .top             (top),
        .dualSlope       (dualSlope),
        .countDown       (countDown),
        .atTop           (atTop),
        .outputModeBits  (outputModeBitsB),
        .toggleAllowed   (1'b0),
        .pinDirectionBit (pinDirection[1]),
        .portValue       (portValue[1]),
        .bufferValue     (),
        .compareValue    (compareValueB),
        .match           (matchB),
        .pinOut          (compareOutputB)
    );

    // flag set events
    logic setOverflow;
    logic setCapture;
    logic [3:0] setFlags;
    assign setOverflow = (dualSlope && tick && atBottom)
                      || (fastPwm && tick && atTop);
    assign setCapture  = topIsCapture && tick && atTop;
    // compare a flag also fires at top when it is the top source
    assign setFlags = {setCapture, matchB, matchA || (topIsCmpA && tick && atTop), setOverflow};

    // control and flag registers; set wins over write-one-to-clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlA           <= CTRL_RESET;
            ctrlB           <= CTRL_RESET;
            captureTopValue <= VALUE_RESET;
            flags           <= 4'h0;
            pinDirection    <= 2'b00;
        end else begin
            if (wrCtrlA) ctrlA <= hwdata[7:0] & 8'hF3;
            if (wrCtrlB) ctrlB <= hwdata[7:0] & 8'h1F;
            if (wrCapTop) captureTopValue <= hwdata[WIDTH-1:0];
            if (wrPinDir) pinDirection <= hwdata[1:0];
            flags <= (flags & ~(wrFlags ? hwdata[3:0] : 4'h0)) | setFlags;
        end
    end

    // read mux
    assign readData = (dataAddr == CTRL_A_OFFSET)  ? {24'h000000, ctrlA} :
                      (dataAddr == CTRL_B_OFFSET)  ? {24'h000000, ctrlB} :
                      (dataAddr == COUNTER_OFFSET) ? {16'h0000, counterValue} :
                      (dataAddr == CMP_A_OFFSET)   ? {16'h0000, compareValueA} :
                      (dataAddr == CMP_B_OFFSET)   ? {16'h0000, compareValueB} :
                      (dataAddr == CAP_TOP_OFFSET) ? {16'h0000, captureTopValue} :
                      (dataAddr == FLAGS_OFFSET)   ? {28'h0000000, flags} :
                      (dataAddr == PIN_DIR_OFFSET) ? {30'h00000000, pinDirection} : 32'h00000000;
    assign hrdata = readData;
endmodule
`default_nettype wire

// >>> timer16_dual_slope_pwm_test.sv
// testbench: bus driver, expected-value queue and pin timing checks for the pwm timer
`timescale 1ns/10ps
`default_nettype none
module timer16_dual_slope_pwm_test;
    import pwm_pkg::*;
    typedef struct {string name; logic [31:0] value;} note_t;
    logic        clk, nrst, hsel, hwrite, arm, pick, probe, rPend, hreadyout, hresp, outA, outB, measValid;
    logic [31:0] haddr, hwdata, hrdata, measValue, rnd;
    logic [1:0]  htrans, portValue;
    note_t       notes[$];
    note_t       note;
    int          badCount, comparisons, cycles, c;
    int          div[5] = '{1, 8, 64, 256, 1024};

    timer16_dual_slope_pwm #(.WIDTH(16)) dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .portValue(portValue), .compareOutputA(outA),
        .compareOutputB(outB));
    pwm_load load (.clk(clk), .pinA(outA), .pinB(outB), .pick(pick), .arm(arm), .measValid(measValid),
        .measValue(measValue));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one single word transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        notes.push_back('{n, e});
        bus(a, 1'b0, 32'h00000000);
    endtask
    // reset, load compares while immediate, then mode and clock
    task automatic setup(input logic [3:0] wgm, input logic [7:0] com, input logic [15:0] top, ca, cb,
                         input logic [2:0] cs);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        bus(CMP_A_OFFSET, 1'b1, {16'h0000, ca});
        bus(CMP_B_OFFSET, 1'b1, {16'h0000, cb});
        bus(CAP_TOP_OFFSET, 1'b1, {16'h0000, top});
        bus(PIN_DIR_OFFSET, 1'b1, 32'h00000003);
        bus(CTRL_A_OFFSET, 1'b1, {24'h000000, com | {6'h00, wgm[1:0]}});
        bus(CTRL_B_OFFSET, 1'b1, {27'h0000000, wgm[3:2], cs});
    endtask
    task automatic pinRun(input logic p, input int per, input int hi);
        notes.push_back('{"pin timing", {hi[15:0], per[15:0]}});
        pick <= p;
        arm <= 1'b1;
        do @(posedge clk); while (measValid !== 1'b1);
        arm <= 1'b0;
    endtask
    task automatic hold(input logic lvl);
        repeat (40) @(posedge clk);
        repeat (3) begin
            notes.push_back('{"pin level", {31'h0, lvl}});
            probe <= 1'b1;
            @(posedge clk);
            probe <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask
    // random port levels and a bounded run
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        portValue <= rnd[1:0];
        cycles++;
        if (cycles == 90000) begin
            badCount++;
            results();
        end
    end
    // take the oldest note whenever a read, timing or level result appears
    always @(posedge clk) begin
        if (rPend || measValid || probe) begin
            note = notes.pop_front();
            check(note.name, rPend ? hrdata : measValid ? measValue : {31'h0, outB}, note.value);
        end
        rPend <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        {nrst, hsel, hwrite, arm, pick, probe, rPend} = 7'h00;
        {haddr, hwdata, htrans, portValue} = 68'h0;
        {badCount, comparisons, cycles} = 96'h0;
        rnd = 32'h0CB59381;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 40; a += 4) rd(a[7:0], 32'h00000000, "reset value");
        bus(8'h24, 1'b1, 32'hFFFFFFFF);
        rd(8'h24, 32'h00000000, "unmapped");
        bus(CTRL_A_OFFSET, 1'b1, 32'h000000FF);
        rd(CTRL_A_OFFSET, 32'h000000F3, "control a");
        $display("test registers done");
        setup(4'h1, 8'h00, 16'h0000, 16'h0000, 16'h0000, 3'h1);
        bus(CMP_A_OFFSET, 1'b1, 32'h0000FFFF);
        bus(CMP_B_OFFSET, 1'b1, 32'h00001234);
        repeat (600) @(posedge clk);
        rd(CMP_A_OFFSET, 32'h000000FF, "masked a");
        rd(CMP_B_OFFSET, 32'h00000034, "masked b");
        $display("test fixed top done");
        for (int m = 8; m < 12; m++) begin
            setup(m[3:0], 8'h00, 16'h0064, m[0] ? 16'h0064 : 16'h003C, 16'h0032, 3'h0);
            bus(COUNTER_OFFSET, 1'b1, 32'h00000062);
            bus(CTRL_B_OFFSET, 1'b1, 32'h00000011);
            bus(CTRL_B_OFFSET, 1'b1, 32'h00000010);
            rd(FLAGS_OFFSET, m[0] ? 32'h00000002 : 32'h00000008, "top flag");
            bus(CTRL_B_OFFSET, 1'b1, 32'h00000011);
            repeat (150) @(posedge clk);
            rd(FLAGS_OFFSET, m[0] ? 32'h00000007 : 32'h0000000F, "all flags");
        end
        $display("test flags done");
        for (int i = 0; i < 5; i++) begin
            c = 1 + int'(rnd[1:0]) % 3;
            setup(4'hA, i[0] ? 8'h30 : 8'h20, 16'h0004, 16'h0004, c[15:0], i[2:0] + 3'h1);
            pinRun(1'b1, 8 * div[i], (i[0] ? 8 - 2 * c : 2 * c) * div[i]);
        end
        setup(4'hE, 8'h20, 16'h0004, 16'h0004, 16'h0000, 3'h1);
        pinRun(1'b1, 5, 1);
        setup(4'hF, 8'h40, 16'h0004, 16'h0000, 16'h0000, 3'h1);
        pinRun(1'b0, 2, 1);
        $display("test pin timing done");
        for (int k = 0; k < 4; k++) begin
            setup(k[1] ? 4'hA : 4'hE, k[0] ? 8'h30 : 8'h20, 16'h0004, 16'h0004, k[1] ? 16'h0000 : 16'h0004, 3'h1);
            hold(k[0] ^ !k[1]);
        end
        $display("test extreme compares done");
        results();
    end
endmodule
`default_nettype wire
